// file: shared/i2c_bus_pkg.sv
// Shared constants, register map and state codes of the two-wire bus interface.
package i2c_bus_pkg;

	localparam int AXI_ADDR_W = 12;
	localparam int AXI_DATA_W = 32;

	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_CONFIG = 10'h03F;
	localparam logic [9:0] IDX_OWN_ADDR = 10'h040;
	localparam logic [9:0] IDX_DIVIDER = 10'h041;
	localparam logic [9:0] IDX_CONTROL = 10'h042;
	localparam logic [9:0] IDX_STATUS = 10'h043;
	localparam logic [9:0] IDX_DATA = 10'h044;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	localparam int CFG_PIN_SEL = 6;
	localparam int CTL_EN = 7;
	localparam int CTL_MASTER = 5;
	localparam int CTL_TX = 4;
	localparam int CTL_TXAK = 3;
	localparam int CTL_RESTART = 2;
	localparam logic [7:0] CTL_MASK = 8'hBC;
	localparam int STS_ARB = 4;
	localparam int STS_EVT = 1;

	localparam logic [7:0] DIVIDER_RESET = 8'h00;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
	localparam logic DONE_RESET = 1'b1;
	localparam logic RXAK_RESET = 1'b1;

	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;

	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] DIV_BASE [8] = '{13'd22, 13'd24, 13'd28, 13'd34,
		13'd44, 13'd48, 13'd56, 13'd68};

	typedef enum logic [7:0] {
		M_IDLE = 8'h01,
		M_START = 8'h02,
		M_HOLD = 8'h04,
		M_LOW = 8'h08,
		M_WAITH = 8'h10,
		M_HIGH = 8'h20,
		M_SETUP = 8'h40,
		M_RISE = 8'h80
	} master_state_e;

	// Each group of eight codes multiplies the base divisor by four.
	function automatic logic [CNT_W-1:0] bit_divisor(input logic [4:0] code);
		bit_divisor = DIV_BASE[code[2:0]] << {code[4:3], 1'b0};
	endfunction

endpackage

// file: hdl/i2c_bus_interface.sv
// Two-wire multi-master bus interface with an AXI4-Lite register slave.
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// - Data changes only while clock low (slave transmitter sets first bit as it releases clock)
// - Eight data bits, MSB first, one pulse each
// - Receiver pulls data low on ninth pulse
// - Slave no-ack: master stops or restarts
// - Master no-ack: slave transmitter releases data
// - STOP is data rising with clock high
// - Master can issue repeated START
// - Clock low longest, high shortest
// - Lose arbitration sending one, reading zero
// - On loss become slave receiver, release lines
// - Loss makes no STOP, sets lost flag
// - Clock fall starts own low count
// - Wait for clock high before high count
// - High count starts when line seen high
// - Slave may stretch clock after byte
// - Pin select picks port D or E pair
// - Port E analog channels blocked when used
// - Configuration read from latches loaded at reset
// - Configuration writable only in special mode
// - Own address in bits 7:1, bit 0 zero
// - Bit clock divisor from five-bit code
// - Divider upper bits zero, resets to zero
// - START is data falling with clock high
// - First byte is address plus direction
module i2c_bus_interface #(
	parameter logic [7:0] CONFIG_NV_DEFAULT = 8'h00
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic por,
	input wire logic special_mode_flag,
	input wire logic [i2c_bus_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [i2c_bus_pkg::AXI_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [i2c_bus_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [i2c_bus_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pd4_in,
	output logic pd4_out,
	output logic pd4_oe_n,
	input wire logic pd3_in,
	output logic pd3_out,
	output logic pd3_oe_n,
	input wire logic pe7_in,
	output logic pe7_out,
	output logic pe7_oe_n,
	input wire logic pe6_in,
	output logic pe6_out,
	output logic pe6_oe_n,
	output logic spi_disable,
	output logic adc_e76_blocked
);
	import i2c_bus_pkg::*;

	function automatic logic map_hit(input logic [AXI_ADDR_W-1:0] a);
		logic [9:0] i;
		i = a[AXI_ADDR_W-1:2];
		map_hit = (a[1:0] == 2'h0) && (i == IDX_CONFIG || i == IDX_OWN_ADDR ||
			i == IDX_DIVIDER || i == IDX_CONTROL || i == IDX_STATUS || i == IDX_DATA);
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	logic aw_got_r, w_got_r, aw_hit_r, w_en_r, bvalid_r, rvalid_r;
	logic [9:0] aw_idx_r;
	logic [7:0] w_val_r, rdata_r;
	logic [1:0] bresp_r, rresp_r;
	logic [7:0] cfg_r, nv_r, ctl_r, data_r, shift_r;
	logic [4:0] div_r;
	logic [6:0] own_r;
	logic done_r, aas_r, busy_r, arb_r, srw_r, evt_r, rxak_r;

	wire aw_fire = s_axi_awvalid & s_axi_awready;
	wire w_fire = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
	wire wr_go = wr_fire & aw_hit_r & w_en_r;
	wire ar_fire = s_axi_arvalid & s_axi_arready;
	wire [9:0] ar_idx = s_axi_araddr[AXI_ADDR_W-1:2];
	wire ar_hit = map_hit(s_axi_araddr);
	wire rd_data_go = ar_fire & ar_hit & (ar_idx == IDX_DATA);
	wire [7:0] status_view = {done_r, aas_r, busy_r, arb_r, 1'b0, srw_r, evt_r, rxak_r};
	wire [7:0] rd_byte = !ar_hit ? 8'h00 :
		(ar_idx == IDX_CONFIG) ? cfg_r :
		(ar_idx == IDX_OWN_ADDR) ? {own_r, 1'b0} :
		(ar_idx == IDX_DIVIDER) ? {3'h0, div_r} :
		(ar_idx == IDX_CONTROL) ? ctl_r :
		(ar_idx == IDX_STATUS) ? status_view : data_r;

	assign s_axi_awready = ~aw_got_r & ~bvalid_r;
	assign s_axi_wready = ~w_got_r & ~bvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = ~rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = {24'h000000, rdata_r};

	always_ff @(posedge core_clk) begin
		if (rst) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_hit_r <= 1'b0;
			w_en_r <= 1'b0;
			aw_idx_r <= 10'h000;
			w_val_r <= 8'h00;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
		end else begin
			if (aw_fire) begin
				aw_got_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[AXI_ADDR_W-1:2];
				aw_hit_r <= map_hit(s_axi_awaddr);
			end
			if (w_fire) begin
				w_got_r <= 1'b1;
				w_val_r <= s_axi_wdata[7:0];
				w_en_r <= s_axi_wstrb[0];
			end
			if (wr_fire) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= aw_hit_r ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 8'h00;
			rresp_r <= RESP_OKAY;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_byte;
			rresp_r <= ar_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	wire wr_cfg = wr_go & (aw_idx_r == IDX_CONFIG);

	// The cells survive rst; only por returns them to their default.
	always_ff @(posedge core_clk) begin
		if (por) begin
			nv_r <= CONFIG_NV_DEFAULT;
		end else if (wr_cfg) begin
			nv_r <= w_val_r;
		end
	end

	// Working latches follow the cells only at reset unless special mode is on.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cfg_r <= por ? CONFIG_NV_DEFAULT : nv_r;
		end else if (wr_cfg && special_mode_flag) begin
			cfg_r <= w_val_r;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_r <= DIVIDER_RESET[4:0];
			own_r <= OWN_ADDR_RESET;
		end else if (wr_go) begin
			if (aw_idx_r == IDX_DIVIDER) begin
				div_r <= w_val_r[4:0];
			end
			if (aw_idx_r == IDX_OWN_ADDR) begin
				own_r <= w_val_r[7:1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin selection and synchronisers.

	logic [3:0] pin_meta_r, pin_sync_r;
	logic scl_prev_r, sda_prev_r, scl_low_r, sda_low_r;
	wire en = ctl_r[CTL_EN];
	wire sel_d = cfg_r[CFG_PIN_SEL];
	wire scl_s = sel_d ? pin_sync_r[3] : pin_sync_r[1];
	wire sda_s = sel_d ? pin_sync_r[2] : pin_sync_r[0];
	wire scl_rise = scl_s & ~scl_prev_r;
	wire scl_fall = ~scl_s & scl_prev_r;
	wire start_det = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
	wire stop_det = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

	assign pd4_out = 1'b0;
	assign pd3_out = 1'b0;
	assign pe7_out = 1'b0;
	assign pe6_out = 1'b0;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_meta_r <= 4'hF;
			pin_sync_r <= 4'hF;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
			pd4_oe_n <= 1'b1;
			pd3_oe_n <= 1'b1;
			pe7_oe_n <= 1'b1;
			pe6_oe_n <= 1'b1;
			spi_disable <= 1'b0;
			adc_e76_blocked <= 1'b0;
		end else begin
			pin_meta_r <= {pd4_in, pd3_in, pe7_in, pe6_in};
			pin_sync_r <= pin_meta_r;
			scl_prev_r <= scl_s;
			sda_prev_r <= sda_s;
			pd4_oe_n <= ~(en & sel_d & scl_low_r);
			pd3_oe_n <= ~(en & sel_d & sda_low_r);
			pe7_oe_n <= ~(en & ~sel_d & scl_low_r);
			pe6_oe_n <= ~(en & ~sel_d & sda_low_r);
			spi_disable <= sel_d;
			adc_e76_blocked <= en & ~sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Byte engine: master bit timing, arbitration and slave responder.

	master_state_e mst_r, mst_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] ctl_nxt, data_nxt, shift_nxt;
	logic scl_low_nxt, sda_low_nxt, pend_r, pend_nxt, stop_r, stop_nxt, first_r, first_nxt;
	logic slv_on_r, slv_on_nxt, addr_ph_r, addr_ph_nxt, slv_tx_r, slv_tx_nxt;
	logic done_nxt, aas_nxt, busy_nxt, arb_nxt, srw_nxt, evt_nxt, rxak_nxt;

	wire [CNT_W-1:0] half_m1 = (bit_divisor(div_r) >> 1) - 13'd1;
	wire cnt_done = (cnt_r == half_m1);
	wire tx_mode = ctl_r[CTL_TX];
	wire wr_ctl = wr_go & (aw_idx_r == IDX_CONTROL);
	wire wr_sts = wr_go & (aw_idx_r == IDX_STATUS);
	wire wr_dat = wr_go & (aw_idx_r == IDX_DATA);

	always_comb begin
		mst_nxt = mst_r;
		cnt_nxt = cnt_done ? '0 : cnt_r + 13'd1;
		bit_cnt_nxt = bit_cnt_r;
		ctl_nxt = ctl_r;
		data_nxt = data_r;
		shift_nxt = shift_r;
		scl_low_nxt = scl_low_r;
		sda_low_nxt = sda_low_r;
		pend_nxt = pend_r;
		stop_nxt = stop_r;
		first_nxt = first_r;
		slv_on_nxt = slv_on_r;
		addr_ph_nxt = addr_ph_r;
		slv_tx_nxt = slv_tx_r;
		done_nxt = done_r;
		aas_nxt = aas_r;
		arb_nxt = arb_r;
		srw_nxt = srw_r;
		evt_nxt = evt_r;
		rxak_nxt = rxak_r;
		busy_nxt = start_det ? 1'b1 : stop_det ? 1'b0 : busy_r;
		// Software effects come first so that hardware sets below win.
		if (wr_ctl) begin
			ctl_nxt = (w_val_r[CTL_EN] || en) ? (w_val_r & CTL_MASK) : CONTROL_RESET;
			aas_nxt = 1'b0;
		end
		if (wr_sts && !w_val_r[STS_ARB]) begin
			arb_nxt = 1'b0;
		end
		if (wr_sts && !w_val_r[STS_EVT]) begin
			evt_nxt = 1'b0;
		end
		if (wr_dat) begin
			data_nxt = w_val_r;
		end
		if (wr_dat || rd_data_go) begin
			pend_nxt = 1'b1;
		end
		unique case (mst_r)
			M_IDLE: begin
				cnt_nxt = '0;
				if (en && ctl_r[CTL_MASTER] && !busy_r && !slv_on_r) begin
					sda_low_nxt = 1'b1;
					first_nxt = 1'b1;
					mst_nxt = M_START;
				end else if (en && start_det) begin
					slv_on_nxt = 1'b1;
					addr_ph_nxt = 1'b1;
					slv_tx_nxt = 1'b0;
					bit_cnt_nxt = '0;
					sda_low_nxt = 1'b0;
					scl_low_nxt = 1'b0;
				end else if (stop_det) begin
					slv_on_nxt = 1'b0;
					sda_low_nxt = 1'b0;
					scl_low_nxt = 1'b0;
				end else if (slv_on_r && scl_low_r) begin
					if (pend_r) begin
						pend_nxt = 1'b0;
						scl_low_nxt = 1'b0;
						if (slv_tx_r) begin
							shift_nxt = data_r;
							sda_low_nxt = ~data_r[7];
						end
					end
				end else if (slv_on_r) begin
					if (scl_rise && bit_cnt_r < ACK_SLOT) begin
						shift_nxt = {shift_r[6:0], sda_s};
					end
					if (scl_rise && bit_cnt_r == ACK_SLOT && slv_tx_r) begin
						rxak_nxt = sda_s;
						if (sda_s) begin
							slv_on_nxt = 1'b0;
							sda_low_nxt = 1'b0;
							done_nxt = 1'b1;
							evt_nxt = 1'b1;
						end
					end
					if (scl_fall) begin
						if (bit_cnt_r == LAST_DATA_BIT) begin
							bit_cnt_nxt = ACK_SLOT;
							if (addr_ph_r) begin
								if (shift_r[7:1] == own_r) begin
									aas_nxt = 1'b1;
									evt_nxt = 1'b1;
									srw_nxt = shift_r[0];
									sda_low_nxt = 1'b1;
								end else begin
									slv_on_nxt = 1'b0;
								end
							end else begin
								sda_low_nxt = ~slv_tx_r;
							end
						end else if (bit_cnt_r == ACK_SLOT) begin
							bit_cnt_nxt = '0;
							sda_low_nxt = 1'b0;
							scl_low_nxt = 1'b1;
							pend_nxt = 1'b0;
							addr_ph_nxt = 1'b0;
							if (addr_ph_r) begin
								slv_tx_nxt = srw_r;
							end else begin
								done_nxt = 1'b1;
								evt_nxt = 1'b1;
								if (!slv_tx_r) begin
									data_nxt = shift_r;
								end
							end
						end else begin
							bit_cnt_nxt = bit_cnt_r + 4'h1;
							if (slv_tx_r) begin
								sda_low_nxt = ~shift_r[7];
							end
						end
					end
				end
			end
			M_START: begin
				if (cnt_done) begin
					scl_low_nxt = 1'b1;
					mst_nxt = M_HOLD;
				end
			end
			M_HOLD: begin
				cnt_nxt = '0;
				if (!scl_s) begin
					sda_low_nxt = 1'b0;
					if (!ctl_r[CTL_MASTER]) begin
						sda_low_nxt = 1'b1;
						stop_nxt = 1'b1;
						mst_nxt = M_SETUP;
					end else if (ctl_r[CTL_RESTART]) begin
						ctl_nxt[CTL_RESTART] = 1'b0;
						stop_nxt = 1'b0;
						mst_nxt = M_SETUP;
					end else if (pend_r) begin
						pend_nxt = 1'b0;
						done_nxt = 1'b0;
						bit_cnt_nxt = '0;
						if (tx_mode) begin
							shift_nxt = data_r;
						end
						mst_nxt = M_LOW;
					end
				end
			end
			M_LOW: begin
				if (cnt_r == '0) begin
					if (bit_cnt_r < ACK_SLOT) begin
						sda_low_nxt = tx_mode & ~shift_r[7];
					end else begin
						sda_low_nxt = ~tx_mode & ~ctl_r[CTL_TXAK];
					end
				end
				if (cnt_done) begin
					scl_low_nxt = 1'b0;
					mst_nxt = M_WAITH;
				end
			end
			M_WAITH: begin
				cnt_nxt = '0;
				if (scl_s) begin
					mst_nxt = M_HIGH;
					if (bit_cnt_r < ACK_SLOT) begin
						shift_nxt = {shift_r[6:0], sda_s};
						if (tx_mode && !sda_low_r && !sda_s) begin
							mst_nxt = M_IDLE;
							scl_low_nxt = 1'b0;
							sda_low_nxt = 1'b0;
							ctl_nxt[CTL_MASTER] = 1'b0;
							ctl_nxt[CTL_TX] = 1'b0;
							arb_nxt = 1'b1;
							evt_nxt = 1'b1;
							slv_on_nxt = 1'b1;
							addr_ph_nxt = first_r;
							slv_tx_nxt = 1'b0;
						end
					end else if (tx_mode) begin
						rxak_nxt = sda_s;
					end
				end
			end
			M_HIGH: begin
				if (scl_fall || cnt_done) begin
					scl_low_nxt = 1'b1;
					cnt_nxt = '0;
					mst_nxt = M_LOW;
					if (bit_cnt_r == ACK_SLOT) begin
						bit_cnt_nxt = '0;
						done_nxt = 1'b1;
						evt_nxt = 1'b1;
						first_nxt = 1'b0;
						mst_nxt = M_HOLD;
						if (!tx_mode) begin
							data_nxt = shift_r;
						end
					end else begin
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end
				end
			end
			M_SETUP: begin
				if (cnt_done) begin
					scl_low_nxt = 1'b0;
					mst_nxt = M_RISE;
				end
			end
			M_RISE: begin
				if (!scl_s) begin
					cnt_nxt = '0;
				end else if (cnt_done) begin
					sda_low_nxt = ~stop_r;
					first_nxt = 1'b1;
					mst_nxt = stop_r ? M_IDLE : M_START;
				end
			end
		endcase
		if (!en) begin
			mst_nxt = M_IDLE;
			bit_cnt_nxt = '0;
			scl_low_nxt = 1'b0;
			sda_low_nxt = 1'b0;
			pend_nxt = 1'b0;
			slv_on_nxt = 1'b0;
			busy_nxt = 1'b0;
			aas_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			mst_r <= M_IDLE;
			cnt_r <= '0;
			bit_cnt_r <= '0;
			ctl_r <= CONTROL_RESET;
			data_r <= 8'h00;
			shift_r <= 8'h00;
			scl_low_r <= 1'b0;
			sda_low_r <= 1'b0;
			{pend_r, stop_r, first_r, slv_on_r, addr_ph_r, slv_tx_r} <= 6'h00;
			{done_r, aas_r, busy_r, arb_r} <= {DONE_RESET, 3'h0};
			{srw_r, evt_r, rxak_r} <= {2'h0, RXAK_RESET};
		end else begin
			mst_r <= mst_nxt;
			cnt_r <= cnt_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			ctl_r <= ctl_nxt;
			data_r <= data_nxt;
			shift_r <= shift_nxt;
			scl_low_r <= scl_low_nxt;
			sda_low_r <= sda_low_nxt;
			{pend_r, stop_r, first_r} <= {pend_nxt, stop_nxt, first_nxt};
			{slv_on_r, addr_ph_r, slv_tx_r} <= {slv_on_nxt, addr_ph_nxt, slv_tx_nxt};
			{done_r, aas_r, busy_r, arb_r} <= {done_nxt, aas_nxt, busy_nxt, arb_nxt};
			{srw_r, evt_r, rxak_r} <= {srw_nxt, evt_nxt, rxak_nxt};
		end
	end

endmodule

// file: verification/i2c_bus_asserts.sv
// Concurrent checks on the ports of the two-wire bus interface.
`timescale 1ns/1ps
module i2c_bus_asserts (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [i2c_bus_pkg::AXI_DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic pd4_oe_n,
	input wire logic pd3_oe_n,
	input wire logic pe7_in,
	input wire logic pe7_out,
	input wire logic pe7_oe_n,
	input wire logic pe6_in,
	input wire logic pe6_out,
	input wire logic pe6_oe_n,
	input wire logic spi_disable,
	input wire logic adc_e76_blocked
);
	import i2c_bus_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	chk_pins_low: assert property (!pe7_out && !pe6_out)
		else $error("bus pin drives a high level");
	chk_pd_parked: assert property (!spi_disable |-> pd4_oe_n && pd3_oe_n)
		else $error("unselected port D pair is pulled");
	chk_pe_parked: assert property (spi_disable |-> pe7_oe_n && pe6_oe_n)
		else $error("unselected port E pair is pulled");
	chk_adc_block: assert property (adc_e76_blocked |-> !spi_disable)
		else $error("analog channels blocked while port D is used");
	// Set only when we let the clock go while another party still holds it low. A fall
	// seen after the line was high is a new low phase, which we are allowed to join.
	logic clk_wait_r;
	always_ff @(posedge core_clk) begin
		if (rst || pe7_in || !pe7_oe_n) begin
			clk_wait_r <= 1'b0;
		end else if ($rose(pe7_oe_n)) begin
			clk_wait_r <= 1'b1;
		end
	end
	chk_clk_wait: assert property (clk_wait_r && !pe7_in && !spi_disable |-> pe7_oe_n)
		else $error("clock pulled while another party holds it low");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before taken");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before taken");
	chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready |=> ##1 s_axi_bvalid)
		else $error("write response late");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && s_axi_rdata[31:8] == 24'h000000)
		else $error("read answer late or upper bits set");
	chk_busy_ready: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	cov_start: cover property ($fell(pe6_in) && pe7_in);
	cov_stretch: cover property (pe7_oe_n && !pe7_in);
	cov_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
bind i2c_bus_interface i2c_bus_asserts chk (.core_clk, .rst, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pd4_oe_n, .pd3_oe_n,
	.pe7_in, .pe7_out, .pe7_oe_n, .pe6_in, .pe6_out, .pe6_oe_n, .spi_disable,
	.adc_e76_blocked);

// file: verification/i2c_slave_model.sv
// Behavioural slave receiver, also able to act as a rival master sending zeros.
`timescale 1ns/1ps
module i2c_slave_model #(
	parameter logic [6:0] ADDR = 7'h52
) (
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda,
	input wire logic fight,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	logic [7:0] sh = 0;
	logic [3:0] cnt = 0;
	logic on = 0;
	logic first = 0;
	initial begin
		scl_pull = 0;
		sda_pull = 0;
		rx_stb = 0;
		rx_byte = 0;
	end
	always @(negedge sda) begin
		if (scl) begin
			on = !fight;
			first = 1;
			cnt = 0;
		end
	end
	always @(posedge sda) begin
		if (scl) on = 0;
	end
	always @(posedge scl) begin
		if (on && cnt < 8) begin
			sh = {sh[6:0], sda};
			cnt = cnt + 1;
		end
	end
	// Pulls are only ever taken at a clock fall, so data moves while the clock is low.
	always @(negedge scl) begin
		if (fight) begin
			sda_pull = 1;
		end else if (on && cnt == 8) begin
			cnt = 9;
			on = !first || sh[7:1] == ADDR;
			sda_pull = on;
			first = 0;
			rx_byte = sh;
			rx_stb = 1;
			#5 rx_stb = 0;
		end else if (cnt == 9) begin
			sda_pull = 0;
			cnt = 0;
			scl_pull = 1;
			repeat (4) @(posedge link_clk);
			scl_pull = 0;
		end
	end
	always @(negedge fight) sda_pull = 0;
endmodule

// file: verification/i2c_bus_interface_bench.sv
// Self-checking bench of the two-wire bus interface.
`timescale 1ns/1ps
module i2c_bus_interface_bench;
	import i2c_bus_pkg::*;
	localparam logic [11:0] A_CFG = {IDX_CONFIG, 2'b00};
	localparam logic [11:0] A_ADR = {IDX_OWN_ADDR, 2'b00};
	localparam logic [11:0] A_DIV = {IDX_DIVIDER, 2'b00};
	localparam logic [11:0] A_CTL = {IDX_CONTROL, 2'b00};
	localparam logic [11:0] A_STS = {IDX_STATUS, 2'b00};
	localparam logic [11:0] A_DAT = {IDX_DATA, 2'b00};
	logic core_clk = 0, link_clk = 0, rst = 1, por = 1, special_mode_flag = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic pd4_out, pd4_oe_n, pd3_out, pd3_oe_n, pe7_out, pe7_oe_n, pe6_out, pe6_oe_n;
	logic spi_disable, adc_e76_blocked, scl_pull, sda_pull, rx_stb, fight = 0;
	logic [7:0] rx_byte, d, r;
	logic [10:0] note;
	int err_total = 0, n_checks = 0, cyc = 0, seed = 45913;
	int lo = 0, lo_min = 9999, lo_ref = 0;
	logic [10:0] rd_q[$];
	logic [1:0] b_q[$];
	logic [7:0] rx_q[$];
	// Released pins float high through the pull-ups.
	wire pe7_in = pe7_oe_n & ~scl_pull;
	wire pe6_in = pe6_oe_n & ~sda_pull;
	wire pd4_in = pd4_oe_n;
	wire pd3_in = pd3_oe_n;
	always #5 core_clk = ~core_clk;
	always #80 link_clk = ~link_clk;
	i2c_bus_interface DUT (.core_clk, .rst, .por, .special_mode_flag, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .pd4_in, .pd4_out, .pd4_oe_n, .pd3_in, .pd3_out, .pd3_oe_n,
		.pe7_in, .pe7_out, .pe7_oe_n, .pe6_in, .pe6_out, .pe6_oe_n, .spi_disable,
		.adc_e76_blocked);
	i2c_slave_model model (.link_clk, .scl(pe7_in), .sda(pe6_in), .fight, .scl_pull,
		.sda_pull, .rx_byte, .rx_stb);
	////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input string nm, input logic [9:0] s, input logic [9:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic do_rst(input logic p);
		@(posedge core_clk);
		rst <= 1;
		por <= p;
		repeat (3) @(posedge core_clk);
		rst <= 0;
		por <= 0;
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] e);
		@(posedge core_clk);
		b_q.push_back(e);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 0;
	endtask
	task automatic axi_rd(input logic [11:0] a, input logic [9:0] e, input logic c,
		output logic [7:0] v);
		@(posedge core_clk);
		rd_q.push_back({c, e});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
		end while (s_axi_rvalid !== 1'b1);
		v = s_axi_rdata[7:0];
		s_axi_rready <= 0;
	endtask
	task automatic poll(input int b, input logic v, output logic [7:0] o);
		o = {8{~v}};
		for (int i = 0; i < 400 && o[b] !== v; i++) begin
			axi_rd(A_STS, 10'h000, 0, o);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic ack);
		logic [7:0] s;
		rx_q.push_back(b);
		axi_wr(A_DAT, b, RESP_OKAY);
		poll(STS_EVT, 1, s);
		cmp("rxak", 10'(s[0]), 10'(!ack));
		axi_wr(A_STS, 8'h00, RESP_OKAY);
	endtask
	////////////////////////////////////////////////////////////
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (!pe7_oe_n) begin
			lo <= lo + 1;
		end else begin
			if (lo > 0 && lo < lo_min) lo_min <= lo;
			lo <= 0;
		end
		if (cyc == 80000) begin
			err_total++;
			results();
		end
		if (s_axi_rvalid && s_axi_rready) begin
			note = rd_q.pop_front();
			if (note[10]) cmp("rdata", {s_axi_rresp, s_axi_rdata[7:0]}, note[9:0]);
		end
		if (s_axi_bvalid && s_axi_bready) cmp("bresp", 10'(s_axi_bresp), 10'(b_q.pop_front()));
	end
	always @(posedge rx_stb) cmp("rx_byte", 10'(rx_byte), 10'(rx_q.pop_front()));
	initial begin
		do_rst(1);
		axi_rd(A_DIV, {RESP_OKAY, DIVIDER_RESET}, 1, d);
		axi_rd(A_ADR, 10'h000, 1, d);
		axi_rd(A_STS, 10'h081, 1, d);
		axi_rd(A_CTL, 10'h000, 1, d);
		axi_rd(12'h200, {RESP_SLVERR, 8'h00}, 1, d);
		axi_wr(12'h200, 8'h55, RESP_SLVERR);
		for (int i = 0; i < 4; i++) begin
			r = (i == 0) ? 8'hFF : 8'($random(seed));
			axi_wr(A_DIV, r, RESP_OKAY);
			axi_rd(A_DIV, {2'h0, r & 8'h1F}, 1, d);
			axi_wr(A_ADR, r, RESP_OKAY);
			axi_rd(A_ADR, {2'h0, r & 8'hFE}, 1, d);
		end
		axi_wr(A_CFG, 8'h40, RESP_OKAY);
		axi_rd(A_CFG, 10'h000, 1, d);
		do_rst(0);
		axi_rd(A_CFG, 10'h040, 1, d);
		cmp("spi_disable", 10'(spi_disable), 10'h001);
		@(posedge core_clk);
		special_mode_flag <= 1;
		axi_wr(A_CFG, 8'h00, RESP_OKAY);
		axi_rd(A_CFG, 10'h000, 1, d);
		axi_wr(A_CTL, 8'h80, RESP_OKAY);
		repeat (2) @(posedge core_clk);
		cmp("adc_block", 10'(adc_e76_blocked), 10'h001);
		axi_wr(A_DIV, 8'h00, RESP_OKAY);
		axi_wr(A_CTL, 8'hB0, RESP_OKAY);
		lo_min = 9999;
		send(8'hA4, 1);
		lo_ref = lo_min;
		// Codes 0 and 1 divide by 22 and 24, so each low phase grows by one cycle.
		axi_wr(A_DIV, 8'h01, RESP_OKAY);
		lo_min = 9999;
		send(8'($random(seed)), 1);
		cmp("low_phase", 10'(lo_min - lo_ref), 10'h001);
		axi_wr(A_CTL, 8'hB4, RESP_OKAY);
		send(8'h30, 0);
		axi_wr(A_CTL, 8'hA0, RESP_OKAY);
		axi_rd(A_DAT, 10'h000, 0, d);
		poll(STS_EVT, 1, d);
		// Nobody drives data after the refused address, so the released line reads ones.
		axi_rd(A_DAT, {RESP_OKAY, 8'hFF}, 1, d);
		axi_wr(A_CTL, 8'h90, RESP_OKAY);
		poll(5, 0, d);
		cmp("busy", 10'(d[5]), 10'h000);
		axi_wr(A_STS, 8'h00, RESP_OKAY);
		fight <= 1;
		axi_wr(A_CTL, 8'hB0, RESP_OKAY);
		axi_wr(A_DAT, 8'hA4, RESP_OKAY);
		poll(STS_ARB, 1, d);
		cmp("arb_evt", 10'({d[STS_ARB], d[STS_EVT]}), 10'h003);
		axi_rd(A_CTL, 10'h080, 1, d);
		fight <= 0;
		cmp("rx_left", 10'(rx_q.size()), 10'h000);
		results();
	end
endmodule
